/* core/pric_defs.svh */
// Offsets, field positions, reset values and constants of the controller.
// Notes on behaviour
// RQ1: Hardware sets request flags; only software clears.
// RQ2: Flags set even while enable is clear.
// RQ3: Software clears flag before enabling the source.
// RQ4: Each source priority 1 to 7, 7 highest.
// RQ5: Priority zero source is never presented.
// RQ6: Priority in low 3 nibble bits; top reads zero.
// RQ7: CPU level is 4 bits, split over two registers; the code keeps all four bits in the one register at 0x14.
// RQ8: Nesting disable blocks new interrupts while servicing.
// RQ9: CPU level ignores writes while nesting disable set.
// RQ10: Timed block masks levels to six; flag set.
// RQ11: Sixty-three 24-bit vectors in program memory 0x04-0xfe.
// RQ12: Normal fetch from vector space raises address error.
// RQ13: Vector word loads program counter through 24-bit mux.
// RQ14: Equal priority: lower interrupt number wins.
// RQ15: Interrupt number n uses vector n plus 8.
// RQ16: Numbers 0 to 16 are the base sources.
// RQ17: Numbers 17-22 and 41 only on larger variant.
// RQ18: Numbers 23,24,25,27,42 fixed; others reserved.
// RQ19: Arbitrate up to 41 sources under one scheme.
// RQ20: Twelve priority registers, last only 8 bits.
// RQ21: Second control: external behaviour, alternate table; first: exceptions.
// RQ22: Sample each instruction cycle; take above CPU level.
// RQ23: On taking, CPU level becomes interrupt priority.
// RQ24: Level bit 3 set only for traps.
// RQ25: Reset clears flags, enables, controls and CPU level.
`ifndef PRIC_DEFS_SVH
`define PRIC_DEFS_SVH

// Register indices on the plain register port (16-bit words).
`define PRIC_REG_FLAGS0 5'h00
`define PRIC_REG_FLAGS2 5'h02
`define PRIC_REG_ENABLES0 5'h03
`define PRIC_REG_ENABLES2 5'h05
`define PRIC_REG_PRIO0 5'h06
`define PRIC_REG_PRIO_LAST 5'h11
`define PRIC_REG_EXC_CTRL 5'h12
`define PRIC_REG_EXT_CTRL 5'h13
`define PRIC_REG_CPU_LEVEL 5'h14

// Field positions.
`define PRIC_NEST_DIS_BIT 15
`define PRIC_ALT_TABLE_BIT 15
`define PRIC_BLOCK_STAT_BIT 14
`define PRIC_LEVEL_TRAP_BIT 3

// Reset values.
`define PRIC_RST_WORD 16'h0000
`define PRIC_RST_LEVEL 4'h0

// Sources, vectors and table placement.
`define PRIC_NUM_FLAGS 48
`define PRIC_NUM_PRIO 46
`define PRIC_VEC_OFFSET 6'h08
`define PRIC_TABLE_BASE 24'h000004
`define PRIC_ALT_TABLE_BASE 24'h000084
`define PRIC_VT_FIRST 24'h000004
`define PRIC_VT_LAST 24'h0000fe
`define PRIC_BLOCK_MAX_PRIO 3'h6
`define PRIC_MASK_SMALL 48'h0400_0b81_ffff
`define PRIC_MASK_LARGE 48'h0600_0bff_ffff

// External request flag positions (numbers 0, 16 and 23).
`define PRIC_EXT0_BIT 0
`define PRIC_EXT1_BIT 16
`define PRIC_EXT2_BIT 23

`endif

/* core/pric_pkg.sv */
// Types shared by the priority interrupt controller.
package pric_pkg;

  // Sequencer states for presenting and vectoring an interrupt.
  typedef enum logic [1:0] {
    PRIC_IDLE = 2'b00,
    PRIC_REQ = 2'b01,
    PRIC_FETCH = 2'b10,
    PRIC_LOAD = 2'b11
  } pric_state_e;

  // Register port request from software.
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pric_bus_s;

  // Interrupt presented to the core.
  typedef struct packed {
    logic req;
    logic [5:0] vector;
    logic [2:0] level;
  } pric_irq_s;

  // Whole state of the controller.
  typedef struct packed {
    pric_state_e st;
    logic [47:0] sync1;
    logic [47:0] sync2;
    logic [47:0] sync3;
    logic [47:0] stable;
    logic [47:0] flags;
    logic [47:0] enables;
    logic [45:0][2:0] prio;
    logic nest_dis;
    logic alt_table;
    logic [2:0] ext_pol;
    logic [3:0] level;
    logic [3:0] depth;
    logic [13:0] block_cnt;
    logic [5:0] win_num;
    logic [2:0] win_prio;
    pric_irq_s irq;
    logic vec_rd;
    logic [23:0] vec_addr;
    logic pc_load;
    logic [23:0] pc_value;
    logic addr_err;
    logic [15:0] rdata;
  } pric_state_s;

endpackage : pric_pkg

/* core/pric_ctrl.sv */
// Priority interrupt controller: flags, enables, arbitration and vectoring.
`include "pric_defs.svh"

module pric_ctrl
  import pric_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire pric_bus_s bus_i,
  output logic [15:0] rdata_o,
  input wire logic [47:0] src_event_i,
  input wire logic instr_cycle_i,
  input wire logic irq_ack_i,
  input wire logic ret_i,
  input wire logic [3:0] ret_level_i,
  input wire logic block_start_i,
  input wire logic [13:0] block_count_i,
  input wire logic fetch_valid_i,
  input wire logic [23:0] fetch_addr_i,
  input wire logic [23:0] pm_rdata_i,
  output pric_irq_s irq_o,
  output logic vec_rd_o,
  output logic [23:0] vec_addr_o,
  output logic pc_load_o,
  output logic [23:0] pc_value_o,
  output logic [3:0] cpu_level_o,
  output logic addr_err_o
);

  // Implemented interrupt numbers for the chosen variant.
  localparam logic [47:0] IMPL_MASK =
    LARGE_VARIANT ? `PRIC_MASK_LARGE : `PRIC_MASK_SMALL; // [RQ16] [RQ17] [RQ18]

  logic [1:0] rst_sync_q; // Reset release synchroniser.
  logic rst_n; // Synchronised reset used by the design.
  pric_state_s s_q; // Registered state.
  pric_state_s s_d; // Next state.
  logic [47:0] ext_sel; // Marks the external request positions.
  logic [47:0] pol_vec; // Polarity per flag position.
  logic [47:0] lvl_old; // Effective event level before this cycle.
  logic [47:0] lvl_new; // Effective event level after this cycle.
  logic [47:0] stable_nx; // Filtered input level.
  logic [47:0] set_ev; // Hardware set requests for the flags.
  logic [47:0] pend; // Flag, enable and implemented together.
  logic [2:0] best_p; // Highest pending priority.
  logic [5:0] best_n; // Number of the winning source.
  logic take; // A request is raised to the core this cycle.
  logic [5:0] vec_num; // Vector number of the latched winner.
  logic [3:0] ridx; // Priority register index under access.
  logic [15:0] rd_word; // Read data before registering.

  // Releases the reset through two flip-flops.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // Positions of the external requests that obey a polarity select.
  always_comb begin
    ext_sel = '0;
    ext_sel[`PRIC_EXT0_BIT] = 1'b1;
    ext_sel[`PRIC_EXT1_BIT] = 1'b1;
    ext_sel[`PRIC_EXT2_BIT] = 1'b1;
    pol_vec = '0;
    pol_vec[`PRIC_EXT0_BIT] = s_q.ext_pol[0];
    pol_vec[`PRIC_EXT1_BIT] = s_q.ext_pol[1];
    pol_vec[`PRIC_EXT2_BIT] = s_q.ext_pol[2];
  end

  // Filters the event inputs: a change counts once stages two and three
  // agree, and a rising effective level raises a flag.
  always_comb begin
    stable_nx = (s_q.sync2 & s_q.sync3) |
      (s_q.stable & (s_q.sync2 ^ s_q.sync3));
    lvl_old = s_q.stable ^ (pol_vec & ext_sel);
    lvl_new = stable_nx ^ (pol_vec & ext_sel);
    set_ev = lvl_new & ~lvl_old & IMPL_MASK; // [RQ1]
  end

  // Finds the winner: highest priority, ties to the lower number.
  always_comb begin
    pend = s_q.flags & s_q.enables & IMPL_MASK; // [RQ19]
    best_p = 3'h0;
    best_n = 6'h00;
    for (int i = 0; i < `PRIC_NUM_PRIO; i++) begin
      // Zero priority can never exceed the start value, so it is
      // never chosen. [RQ5]
      if (pend[i] && (s_q.prio[i] > best_p)) begin // [RQ4] [RQ14]
        best_p = s_q.prio[i];
        best_n = 6'(i);
      end
    end
  end

  // Decides whether the winner may interrupt the core now.
  always_comb begin
    take = instr_cycle_i && (s_q.st == PRIC_IDLE) &&
      (best_p != 3'h0) &&
      ({1'b0, best_p} > s_q.level); // [RQ22] [RQ24]
    if (s_q.nest_dis && (s_q.depth != 4'h0)) begin
      take = 1'b0; // [RQ8]
    end
    if ((s_q.block_cnt != 14'h0) && (best_p <= `PRIC_BLOCK_MAX_PRIO)) begin
      take = 1'b0; // [RQ10]
    end
  end

  // Vector number and priority register index.
  assign vec_num = s_q.win_num + `PRIC_VEC_OFFSET; // [RQ15]
  assign ridx = 4'(bus_i.addr - `PRIC_REG_PRIO0);

  // Builds the read word for the addressed register.
  always_comb begin
    rd_word = 16'h0000;
    if (bus_i.addr <= `PRIC_REG_FLAGS2) begin
      rd_word = s_q.flags[bus_i.addr[1:0]*16 +: 16];
    end else if (bus_i.addr <= `PRIC_REG_ENABLES2) begin
      // The word index is cut to two bits so that it cannot go negative.
      rd_word = s_q.enables[2'(bus_i.addr - `PRIC_REG_ENABLES0)*16 +: 16];
    end else if (bus_i.addr <= `PRIC_REG_PRIO_LAST) begin
      // Bit 3 of each nibble stays zero. [RQ6] [RQ20]
      for (int k = 0; k < 4; k++) begin
        if ((int'(ridx) * 4 + k) < `PRIC_NUM_PRIO) begin
          rd_word[k*4 +: 4] = {1'b0, s_q.prio[int'(ridx) * 4 + k]};
        end
      end
    end else if (bus_i.addr == `PRIC_REG_EXC_CTRL) begin
      rd_word[`PRIC_NEST_DIS_BIT] = s_q.nest_dis; // [RQ21]
    end else if (bus_i.addr == `PRIC_REG_EXT_CTRL) begin
      rd_word[`PRIC_ALT_TABLE_BIT] = s_q.alt_table; // [RQ21]
      rd_word[`PRIC_BLOCK_STAT_BIT] = (s_q.block_cnt != 14'h0); // [RQ10]
      rd_word[2:0] = s_q.ext_pol;
    end else if (bus_i.addr == `PRIC_REG_CPU_LEVEL) begin
      rd_word[3:0] = s_q.level; // [RQ7]
    end
  end

  // Computes the next state of the whole controller.
  always_comb begin
    s_d = s_q;
    s_d.sync1 = src_event_i;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.stable = stable_nx;
    s_d.vec_rd = 1'b0;
    s_d.pc_load = 1'b0;
    // Normal fetch inside the vector space is an address error. [RQ12]
    s_d.addr_err = fetch_valid_i && (fetch_addr_i >= `PRIC_VT_FIRST) &&
      (fetch_addr_i <= `PRIC_VT_LAST);
    if (bus_i.rd) begin
      s_d.rdata = rd_word;
    end

    // Software writes to the registers.
    if (bus_i.wr) begin
      if (bus_i.addr <= `PRIC_REG_FLAGS2) begin
        s_d.flags[bus_i.addr[1:0]*16 +: 16] = bus_i.wdata;
      end else if (bus_i.addr <= `PRIC_REG_ENABLES2) begin
        s_d.enables[2'(bus_i.addr - `PRIC_REG_ENABLES0)*16 +: 16] =
          bus_i.wdata;
      end else if (bus_i.addr <= `PRIC_REG_PRIO_LAST) begin
        for (int k = 0; k < 4; k++) begin
          if ((int'(ridx) * 4 + k) < `PRIC_NUM_PRIO) begin
            s_d.prio[int'(ridx) * 4 + k] = bus_i.wdata[k*4 +: 3]; // [RQ6]
          end
        end
      end else if (bus_i.addr == `PRIC_REG_EXC_CTRL) begin
        s_d.nest_dis = bus_i.wdata[`PRIC_NEST_DIS_BIT];
      end else if (bus_i.addr == `PRIC_REG_EXT_CTRL) begin
        s_d.alt_table = bus_i.wdata[`PRIC_ALT_TABLE_BIT];
        s_d.ext_pol = bus_i.wdata[2:0];
      end else if (bus_i.addr == `PRIC_REG_CPU_LEVEL) begin
        if (!s_q.nest_dis) begin
          s_d.level = bus_i.wdata[3:0]; // [RQ7] [RQ9]
        end
      end
    end

    // Hardware set wins over a software clear in the same cycle, and
    // does not look at the enable bits.
    s_d.flags = s_d.flags | set_ev; // [RQ1] [RQ2]

    // Timed block counts instruction cycles down.
    if (block_start_i) begin
      s_d.block_cnt = block_count_i; // [RQ10]
    end else if (instr_cycle_i && (s_q.block_cnt != 14'h0)) begin
      s_d.block_cnt = s_q.block_cnt - 14'h1; // [RQ10]
    end

    // Return from a service routine restores the stacked level.
    if (ret_i) begin
      s_d.level = ret_level_i;
      if (s_q.depth != 4'h0) begin
        s_d.depth = s_q.depth - 4'h1;
      end
    end

    // Sequencer that presents and vectors one interrupt.
    case (s_q.st)
      PRIC_IDLE: begin
        if (take) begin
          s_d.win_num = best_n;
          s_d.win_prio = best_p;
          s_d.irq.req = 1'b1;
          s_d.irq.vector = best_n + `PRIC_VEC_OFFSET; // [RQ15]
          s_d.irq.level = best_p;
          s_d.st = PRIC_REQ;
        end
      end
      PRIC_REQ: begin
        if (irq_ack_i) begin
          s_d.irq.req = 1'b0;
          s_d.vec_rd = 1'b1;
          // Each vector is one program word; the table base follows the
          // alternate select. [RQ11]
          s_d.vec_addr = (s_q.alt_table ? `PRIC_ALT_TABLE_BASE :
            `PRIC_TABLE_BASE) + {17'h0, vec_num, 1'b0};
          s_d.st = PRIC_FETCH;
        end
      end
      PRIC_FETCH: begin
        s_d.st = PRIC_LOAD;
      end
      PRIC_LOAD: begin
        s_d.pc_value = pm_rdata_i; // [RQ13]
        s_d.pc_load = 1'b1; // [RQ13]
        s_d.level = {1'b0, s_q.win_prio}; // [RQ23] [RQ24]
        s_d.depth = s_q.depth + 4'h1;
        s_d.st = PRIC_IDLE;
      end
      default: begin
        s_d.st = PRIC_IDLE;
      end
    endcase
  end

  // Registers the state; reset clears every field. [RQ25]
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign rdata_o = s_q.rdata;
  assign irq_o = s_q.irq;
  assign vec_rd_o = s_q.vec_rd;
  assign vec_addr_o = s_q.vec_addr;
  assign pc_load_o = s_q.pc_load;
  assign pc_value_o = s_q.pc_value;
  assign cpu_level_o = s_q.level;
  assign addr_err_o = s_q.addr_err;

endmodule : pric_ctrl

/* verification/pric_ctrl_monitor.sv */
// Checker for the core link, register reads and the fetch guard.
module pric_ctrl_checker
  import pric_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire pric_bus_s bus_i,
  input wire logic [15:0] rdata_o,
  input wire logic irq_ack_i,
  input wire logic fetch_valid_i,
  input wire logic [23:0] fetch_addr_i,
  input wire logic [23:0] pm_rdata_i,
  input wire pric_irq_s irq_o,
  input wire logic vec_rd_o,
  input wire logic pc_load_o,
  input wire logic [23:0] pc_value_o,
  input wire logic [3:0] cpu_level_o,
  input wire logic addr_err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every check runs on the system clock and sleeps in reset.
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  chk_ack_fetch: assert property (
    irq_o.req && irq_ack_i |=> vec_rd_o && !irq_o.req)
    else $error("vector read missing after acknowledge");
  chk_load_time: assert property (vec_rd_o |-> ##2 pc_load_o)
    else $error("program counter load late");
  chk_pc_word: assert property (
    pc_load_o |-> pc_value_o == $past(pm_rdata_i))
    else $error("program counter not loaded with vector word");
  chk_vec_range: assert property (
    irq_o.req |-> irq_o.vector inside {[6'h08:6'h3d]})
    else $error("vector number out of range");
  chk_prio_zero: assert property (
    irq_o.req |-> irq_o.level != 3'h0)
    else $error("priority zero source presented");
  chk_above_cpu: assert property (
    $rose(irq_o.req) |-> {1'b0, irq_o.level} > cpu_level_o)
    else $error("request not above cpu level");
  chk_level_load: assert property (
    pc_load_o |-> cpu_level_o == {1'b0, $past(irq_o.level, 3)})
    else $error("cpu level not loaded with priority");
  chk_fetch_guard: assert property (
    fetch_valid_i |=> addr_err_o ==
      ($past(fetch_addr_i) inside {[24'h000004:24'h0000fe]}))
    else $error("address error flag wrong");
  chk_prio_pad: assert property (
    bus_i.rd && bus_i.addr inside {[5'h06:5'h11]} |=>
      (rdata_o & 16'h8888) == 16'h0000)
    else $error("unused priority bit reads one");
  chk_req_hold: assert property (
    irq_o.req && !irq_ack_i |=> irq_o.req && $stable(irq_o.vector))
    else $error("request dropped before acknowledge");
  // Main scenarios: a request, a vector load and a fetch fault.
  cov_raise: cover property ($rose(irq_o.req));
  cov_load: cover property (pc_load_o);
  cov_fault: cover property (addr_err_o);
endmodule : pric_ctrl_checker

bind pric_ctrl pric_ctrl_checker u_chk (.sys_clk_i, .resetn_i, .bus_i,
  .rdata_o, .irq_ack_i, .fetch_valid_i, .fetch_addr_i, .pm_rdata_i, .irq_o,
  .vec_rd_o, .pc_load_o, .pc_value_o, .cpu_level_o, .addr_err_o);

/* verification/pric_core_model.sv */
// Processor core stand-in: instruction ticks, acknowledge, vector memory.
module pric_core_model
  import pric_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [2:0] ack_wait_i,
  input wire pric_irq_s irq_i,
  input wire logic vec_rd_i,
  input wire logic [23:0] vec_addr_i,
  output logic instr_cycle_o,
  output logic irq_ack_o,
  output logic [23:0] pm_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_q; // Position inside a four-clock instruction.
  logic [2:0] wait_q; // Clocks left before the acknowledge.
  // Start from a known state so the design never sees unknowns.
  initial begin
    tick_q = 2'h0;
    wait_q = 3'h0;
    instr_cycle_o = 1'b0;
    irq_ack_o = 1'b0;
    pm_rdata_o = 24'h000000;
  end
  // One instruction tick every fourth clock.
  always @(posedge sys_clk_i) begin
    tick_q <= tick_q + 2'h1;
    instr_cycle_o <= (tick_q == 2'h3);
  end
  // Acknowledge a presented request after the chosen wait, for one clock.
  always @(posedge sys_clk_i) begin
    if (!irq_i.req) begin
      wait_q <= ack_wait_i;
    end else if (wait_q != 3'h0) begin
      wait_q <= wait_q - 3'h1;
    end
    irq_ack_o <= irq_i.req && !irq_ack_o && (wait_q == 3'h0);
  end
  // Vector word stands one clock after the read, then the bus scrambles.
  always @(posedge sys_clk_i) begin
    pm_rdata_o <= vec_rd_i ? {8'h5a, vec_addr_i[15:0]} :
      ~pm_rdata_o;
  end
endmodule : pric_core_model

/* verification/test_priority_interrupt_controller.sv */
// Self-checking bench for the priority interrupt controller.
module test_priority_interrupt_controller
  import pric_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0; // Held low from time zero.
  pric_bus_s bus_i = '0;
  logic [47:0] src_event_i = '0;
  logic ret_i = 1'b0;
  logic [3:0] ret_level_i = 4'h0; // Returns always restore level zero.
  logic block_start_i = 1'b0;
  logic [13:0] block_count_i = 14'h0000;
  logic fetch_valid_i = 1'b0;
  logic [23:0] fetch_addr_i = 24'h000000;
  logic [2:0] ack_wait_i = 3'h0;
  logic [23:0] vt_base = 24'h000004; // Expected base of the vector table.
  logic instr_cycle_i, irq_ack_i, vec_rd_o, pc_load_o, addr_err_o;
  logic [23:0] pm_rdata_i, vec_addr_o, pc_value_o;
  logic [15:0] rdata_o;
  logic [3:0] cpu_level_o;
  pric_irq_s irq_o;
  int failures = 0;
  int samples_checked = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  pric_ctrl #(.LARGE_VARIANT(1'b1)) dut (.sys_clk_i, .resetn_i, .bus_i,
    .rdata_o, .src_event_i, .instr_cycle_i, .irq_ack_i, .ret_i, .ret_level_i,
    .block_start_i, .block_count_i, .fetch_valid_i, .fetch_addr_i,
    .pm_rdata_i, .irq_o, .vec_rd_o, .vec_addr_o, .pc_load_o, .pc_value_o,
    .cpu_level_o, .addr_err_o);
  pric_core_model core (.sys_clk_i, .ack_wait_i, .irq_i(irq_o),
    .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o),
    .instr_cycle_o(instr_cycle_i), .irq_ack_o(irq_ack_i),
    .pm_rdata_o(pm_rdata_i));
  // Compare one value and count it.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Print the verdict and stop.
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // Reset for twelve clocks; sources drop back to idle.
  task automatic rst();
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    src_event_i <= '0;
    repeat (12) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask : rst
  // One-cycle register write.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_i <= '0;
  endtask : wr
  // One-cycle register read; data checked in the following cycle.
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge sys_clk_i);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus_i <= '0;
    #1;
    chk({8'h00, rdata_o}, {8'h00, e});
  endtask : rd
  // Raise source events; they stay high until the next reset.
  task automatic fire(input logic [47:0] m);
    @(posedge sys_clk_i);
    src_event_i <= src_event_i | m;
  endtask : fire
  // Pulse the return-from-interrupt strobe.
  task automatic ret();
    @(posedge sys_clk_i);
    ret_i <= 1'b1;
    @(posedge sys_clk_i);
    ret_i <= 1'b0;
  endtask : ret
  // Expect no request for forty clocks.
  task automatic no_irq();
    int n;
    n = 0;
    repeat (40) begin
      @(posedge sys_clk_i);
      #1;
      if (irq_o.req !== 1'b0) n++;
    end
    chk(24'(n), 24'h000000);
  endtask : no_irq
  // Wait for a request, check it and the vector load that follows.
  task automatic take(input logic [5:0] v, input logic [2:0] l);
    logic [23:0] a;
    int n;
    a = vt_base + {17'h00000, v, 1'b0};
    n = 0;
    while (irq_o.req !== 1'b1 && n < 80) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk({18'h0, irq_o.vector}, {18'h0, v});
    chk({21'h0, irq_o.level}, {21'h0, l});
    while (pc_load_o !== 1'b1 && n < 120) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(vec_addr_o, a);
    chk(pc_value_o, {8'h5a, a[15:0]});
    chk({20'h0, cpu_level_o}, {21'h0, l});
  endtask : take
  // Cut a hang short.
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    logic [23:0] fa[4];
    fa = '{24'h000003, 24'h000004, 24'h0000fe, 24'h0000ff};
    rst();
    for (int a = 0; a < 32; a++) rd(5'(a), 16'h0000);
    wr(5'h06, 16'hffff);
    rd(5'h06, 16'h7777);
    wr(5'h11, 16'hffff);
    rd(5'h11, 16'h0077);
    wr(5'h13, 16'hffff);
    rd(5'h13, 16'h8007);
    wr(5'h1f, 16'hffff);
    rd(5'h1f, 16'h0000);
    foreach (fa[i]) begin
      @(posedge sys_clk_i);
      fetch_valid_i <= 1'b1;
      fetch_addr_i <= fa[i];
      @(posedge sys_clk_i);
      fetch_valid_i <= 1'b0;
      #1;
      chk({23'h0, addr_err_o}, {23'h0, i == 1 || i == 2});
    end
    // Flag sets while disabled and clears only by a write.
    rst();
    fire(48'h000000000008);
    repeat (8) @(posedge sys_clk_i);
    rd(5'h00, 16'h0008);
    wr(5'h00, 16'h0000);
    rd(5'h00, 16'h0000);
    // Equal priority: the lower number wins, the other waits.
    rst();
    wr(5'h06, 16'h0440);
    wr(5'h03, 16'h0006);
    fire(48'h000000000006);
    take(6'h09, 3'h4);
    no_irq();
    wr(5'h00, 16'h0004);
    ret();
    take(6'h0a, 3'h4);
    // Priority zero is silent; the cpu level gates a high number.
    rst();
    wr(5'h03, 16'h0020);
    fire(48'h000000000020);
    no_irq();
    wr(5'h14, 16'h0005);
    rd(5'h14, 16'h0005);
    wr(5'h10, 16'h0500);
    wr(5'h00, 16'h0000);
    wr(5'h05, 16'h0400);
    fire(48'h040000000000);
    no_irq();
    wr(5'h14, 16'h0004);
    take(6'h32, 3'h5);
    // Nesting disabled, with a slow acknowledge.
    rst();
    ack_wait_i <= 3'h3;
    wr(5'h12, 16'h8000);
    wr(5'h06, 16'h3700);
    wr(5'h03, 16'h000c);
    fire(48'h000000000008);
    take(6'h0b, 3'h3);
    fire(48'h000000000004);
    no_irq();
    wr(5'h14, 16'h0000);
    rd(5'h14, 16'h0003);
    ret();
    take(6'h0a, 3'h7);
    // Timed block holds back priority six but not seven.
    rst();
    wr(5'h06, 16'h0076);
    wr(5'h03, 16'h0003);
    // The vector is fetched from the alternate table here.
    wr(5'h13, 16'h8000);
    vt_base = 24'h000084;
    @(posedge sys_clk_i);
    block_start_i <= 1'b1;
    block_count_i <= 14'h001e;
    @(posedge sys_clk_i);
    block_start_i <= 1'b0;
    rd(5'h13, 16'hc000);
    fire(48'h000000000001);
    no_irq();
    fire(48'h000000000002);
    take(6'h09, 3'h7);
    repeat (100) @(posedge sys_clk_i);
    rd(5'h13, 16'h8000);
    wrap_up();
  end
endmodule : test_priority_interrupt_controller
